// >>> include/aqh_pkg.sv
// Constants and register map for the asynchronous queue host port
package aqh_pkg;

    // APB address width and register byte offsets
    localparam int AQH_ADDR_W = 12;
    localparam logic [AQH_ADDR_W-1:0] AQH_OFF_ASYNC_QUEUE_STATUS = 12'h084;
    localparam logic [AQH_ADDR_W-1:0] AQH_OFF_TX_REQUEST_NEXT_QUADLET = 12'h088;
    localparam logic [AQH_ADDR_W-1:0] AQH_OFF_TX_REQUEST_LAST_QUADLET = 12'h08c;
    localparam logic [AQH_ADDR_W-1:0] AQH_OFF_TX_RESPONSE_NEXT_QUADLET = 12'h090;
    localparam logic [AQH_ADDR_W-1:0] AQH_OFF_TX_RESPONSE_LAST_QUADLET = 12'h094;
    localparam logic [AQH_ADDR_W-1:0] AQH_OFF_IRQ_STATUS = 12'h0c0;
    localparam logic [AQH_ADDR_W-1:0] AQH_OFF_IRQ_MASK = 12'h0c4;
    localparam logic [AQH_ADDR_W-1:0] AQH_OFF_WRITE_READY = 12'h0c8;

    // Reset values
    localparam logic [31:0] AQH_STATUS_RESET = 32'h00033333;
    localparam logic [5:0] AQH_IRQ_MASK_RESET = 6'h00;

    // Status word: idle bits and per-queue flag nibble
    localparam int AQH_TX_RESP_IDLE_BIT = 17;
    localparam int AQH_TX_REQ_IDLE_BIT = 16;
    localparam int AQH_FLAG_EMPTY = 0;
    localparam int AQH_FLAG_FIVE_FREE = 1;
    localparam int AQH_FLAG_ONE_LEFT = 2;
    localparam int AQH_FLAG_FULL = 3;

    // Queue indices and the low bit of each queue's flag nibble
    localparam int AQH_NUM_QUEUES = 4;
    localparam int AQH_Q_TX_REQ = 0;
    localparam int AQH_Q_TX_RESP = 1;
    localparam int AQH_Q_RX_REQ = 2;
    localparam int AQH_Q_RX_RESP = 3;
    localparam int AQH_NIBBLE_BASE [AQH_NUM_QUEUES] = '{0, 4, 8, 12};

    // Interrupt status bits
    localparam int AQH_IRQ_W = 6;
    localparam int AQH_IRQ_TX_REQ_MOVED = 0;
    localparam int AQH_IRQ_TX_RESP_MOVED = 1;
    localparam int AQH_IRQ_RX_REQ_ARRIVED = 2;
    localparam int AQH_IRQ_RX_RESP_ARRIVED = 3;
    localparam int AQH_IRQ_TX_REQ_OVERRUN = 4;
    localparam int AQH_IRQ_TX_RESP_OVERRUN = 5;

    // Write-ready register bits
    localparam int AQH_WR_TX_REQ_READY_BIT = 0;
    localparam int AQH_WR_TX_RESP_READY_BIT = 1;

    // Queue geometry
    localparam int AQH_QUEUE_DEPTH = 16;
    localparam int AQH_MIN_DEPTH = 5;
    localparam int AQH_FIVE = 5;
    localparam int AQH_QUADLET_W = 32;

endpackage

// >>> verification/aqh_async_queue_host_port_tb_top.sv
// Testbench for the asynchronous queue host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, a); end end
module aqh_async_queue_host_port_tb_top
    import aqh_pkg::*;
;
    localparam int QD = 6;
    logic pclk, presetn;
    wire psel, penable, pwrite, pready, pslverr, irq;
    wire [AQH_ADDR_W-1:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [31:0] od [4];
    wire [3:0] ov, ol;
    wire [1:0] rx_rdy;
    logic [3:0] ordy;
    logic [1:0] rx_iv, rx_il;
    logic [31:0] rx_id [2];
    logic [32:0] got [4][$];
    logic [31:0] rd;
    logic err;
    int error_cnt, total_checks;
    aqh_async_queue_host_port #(.QUEUE_DEPTH(QD)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
        .tx_req_data(od[0]), .tx_req_last(ol[0]), .tx_req_valid(ov[0]), .tx_req_ready(ordy[0]),
        .tx_resp_data(od[1]), .tx_resp_last(ol[1]), .tx_resp_valid(ov[1]), .tx_resp_ready(ordy[1]),
        .rx_req_in_data(rx_id[0]), .rx_req_in_last(rx_il[0]), .rx_req_in_valid(rx_iv[0]),
        .rx_req_in_ready(rx_rdy[0]), .rx_resp_in_data(rx_id[1]), .rx_resp_in_last(rx_il[1]),
        .rx_resp_in_valid(rx_iv[1]), .rx_resp_in_ready(rx_rdy[1]),
        .rx_req_out_data(od[2]), .rx_req_out_last(ol[2]), .rx_req_out_valid(ov[2]), .rx_req_out_ready(ordy[2]),
        .rx_resp_out_data(od[3]), .rx_resp_out_last(ol[3]), .rx_resp_out_valid(ov[3]),
        .rx_resp_out_ready(ordy[3])
    );
    aqh_host_model host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    always #5 pclk = ~pclk;
    // Collect every quadlet handed over on the four queue outputs
    always @(posedge pclk) begin
        for (int k = 0; k < 4; k++) begin
            if (ov[k] && ordy[k]) got[k].push_back({ol[k], od[k]});
        end
    end
    function automatic logic [3:0] nib(input int c);
        return {c == QD, c == QD - 1, QD - c >= 5, c == 0};
    endfunction
    task automatic rdr(input logic [AQH_ADDR_W-1:0] a);
        host.xfer(1'b0, a, 32'h0, rd, err);
    endtask
    task stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tx_path(input int p);
        logic [AQH_ADDR_W-1:0] an, al;
        int b;
        an = p ? AQH_OFF_TX_RESPONSE_NEXT_QUADLET : AQH_OFF_TX_REQUEST_NEXT_QUADLET;
        al = p ? AQH_OFF_TX_RESPONSE_LAST_QUADLET : AQH_OFF_TX_REQUEST_LAST_QUADLET;
        b = 4 * p;
        rdr(AQH_OFF_IRQ_STATUS);
        ordy[p] <= 1'b1;
        host.xfer(1'b1, al, 32'h0a0, rd, err);
        repeat (4) @(posedge pclk);
        ordy[p] <= 1'b0;
        `CHK("single packet", {1'b1, 32'h0a0}, got[p].pop_front())
        `CHK("irq masked", 1'b0, irq)
        for (int i = 0; i < 8; i++) begin
            host.xfer(1'b1, (i == 5 || i == 7) ? al : an, 32'h100 + i, rd, err);
            if (i < 7) begin
                rdr(AQH_OFF_ASYNC_QUEUE_STATUS);
                `CHK("tx flags", nib(i < 6 ? i + 1 : QD), rd[b+:4])
                `CHK("tx idle", i < 6, rd[16+p])
            end
        end
        rdr(AQH_OFF_WRITE_READY);
        `CHK("write ready", 2'b11 ^ (2'b01 << p), rd[1:0])
        `CHK("irq overrun", 1'b1, irq)
        rdr(AQH_OFF_IRQ_STATUS);
        `CHK("irq status", 6'h00 | (6'h01 << p) | (6'h10 << p), rd[5:0])
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        ordy[p] <= 1'b1;
        repeat (12) @(posedge pclk);
        ordy[p] <= 1'b0;
        for (int i = 0; i < 7; i++) `CHK("tx pop", {i == 5, 32'h100 + i}, got[p].pop_front())
        `CHK("overrun dropped", 0, got[p].size())
        $display("test tx path %0d done", p);
    endtask
    task automatic rx_path(input int q);
        for (int i = 0; i < QD; i++) begin
            rx_id[q] <= 32'h300 + i;
            rx_il[q] <= (i == QD - 1);
            rx_iv[q] <= 1'b1;
            @(posedge pclk);
            while (rx_rdy[q] !== 1'b1) @(posedge pclk);
            rx_iv[q] <= 1'b0;
            rdr(AQH_OFF_ASYNC_QUEUE_STATUS);
            `CHK("rx flags", nib(i + 1), rd[8+4*q+:4])
        end
        `CHK("rx full refused", 1'b0, rx_rdy[q])
        ordy[q+2] <= 1'b1;
        repeat (10) @(posedge pclk);
        ordy[q+2] <= 1'b0;
        for (int i = 0; i < QD; i++) `CHK("rx pop", {i == QD - 1, 32'h300 + i}, got[q+2].pop_front())
        $display("test rx path %0d done", q);
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ordy = 4'h0;
        rx_iv = 2'b00;
        rx_il = 2'b00;
        rx_id[0] = 32'h0;
        rx_id[1] = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        host.xfer(1'b1, AQH_OFF_ASYNC_QUEUE_STATUS, 32'hffffffff, rd, err);
        `CHK("status write refused", 1'b1, err)
        rdr(AQH_OFF_ASYNC_QUEUE_STATUS);
        `CHK("status reset", AQH_STATUS_RESET, rd)
        rdr(AQH_OFF_TX_REQUEST_NEXT_QUADLET);
        `CHK("write only read", 1'b1, err)
        rdr(12'h0fc);
        `CHK("unmapped read", 1'b1, err)
        rdr(AQH_OFF_IRQ_MASK);
        `CHK("mask reset", 32'h00000000, rd)
        host.xfer(1'b1, AQH_OFF_IRQ_MASK, 32'h00000030, rd, err);
        $display("test reset done");
        for (int p = 0; p < 2; p++) tx_path(p);
        for (int q = 0; q < 2; q++) rx_path(q);
        rdr(AQH_OFF_ASYNC_QUEUE_STATUS);
        `CHK("status drained", AQH_STATUS_RESET, rd)
        stop_test();
    end
    initial begin
        #100us;
        error_cnt++;
        $display("ERROR watchdog exp done got timeout");
        stop_test();
    end
endmodule
`default_nettype wire

// >>> verification/aqh_host_model.sv
// APB host model that reads and writes the queue registers
`timescale 1ns/1ps
`default_nettype none
module aqh_host_model
    import aqh_pkg::*;
(
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [AQH_ADDR_W-1:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
    end
    // One transfer; request held until pready is seen high
    task automatic xfer(input logic wr, input logic [AQH_ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verification/aqh_port_sva.sv
// Port checker for the asynchronous queue host port
`timescale 1ns/1ps
`default_nettype none
module aqh_port_sva
    import aqh_pkg::*;
#(
    parameter int QUEUE_DEPTH = AQH_QUEUE_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AQH_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [AQH_QUADLET_W-1:0] tx_req_data,
    input wire logic tx_req_last,
    input wire logic tx_req_valid,
    input wire logic tx_req_ready,
    input wire logic tx_resp_last,
    input wire logic tx_resp_valid,
    input wire logic rx_req_in_valid,
    input wire logic rx_req_in_ready,
    input wire logic rx_req_out_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    wire logic to_xfer = paddr inside {[AQH_OFF_TX_REQUEST_NEXT_QUADLET:AQH_OFF_TX_RESPONSE_LAST_QUADLET]};
    a_status_unused_zero: assert property (
        acc && !pwrite && paddr == AQH_OFF_ASYNC_QUEUE_STATUS |-> prdata[31:18] == 14'h0000 && !pslverr)
        else $error("status word unused bits not zero");
    a_req_next_queued: assert property (
        acc && pwrite && paddr == AQH_OFF_TX_REQUEST_NEXT_QUADLET && !tx_req_valid |-> ##[1:3] tx_req_valid)
        else $error("request next quadlet never reached queue");
    a_req_last_queued: assert property (
        acc && pwrite && paddr == AQH_OFF_TX_REQUEST_LAST_QUADLET && !tx_req_valid
        |-> ##[1:3] (tx_req_valid && tx_req_last))
        else $error("request last quadlet not queued as packet end");
    a_resp_next_queued: assert property (
        acc && pwrite && paddr == AQH_OFF_TX_RESPONSE_NEXT_QUADLET && !tx_resp_valid |-> ##[1:3] tx_resp_valid)
        else $error("response next quadlet never reached queue");
    a_resp_last_queued: assert property (
        acc && pwrite && paddr == AQH_OFF_TX_RESPONSE_LAST_QUADLET && !tx_resp_valid
        |-> ##[1:3] (tx_resp_valid && tx_resp_last))
        else $error("response last quadlet not queued as packet end");
    a_wrong_dir_err: assert property (
        acc && (to_xfer && !pwrite || paddr == AQH_OFF_ASYNC_QUEUE_STATUS && pwrite) |-> pslverr)
        else $error("wrong direction access not refused");
    a_head_holds: assert property (
        tx_req_valid && !tx_req_ready |=> tx_req_valid && $stable(tx_req_data) && $stable(tx_req_last))
        else $error("request queue head changed while stalled");
    a_rx_passes: assert property (
        rx_req_in_valid && rx_req_in_ready && !rx_req_out_valid |-> ##[1:2] rx_req_out_valid)
        else $error("received request quadlet not offered");
    c_req_write: cover property (acc && pwrite && paddr == AQH_OFF_TX_REQUEST_NEXT_QUADLET);
    c_req_packet_end: cover property (tx_req_valid && tx_req_last && tx_req_ready);
    c_rx_refused: cover property (rx_req_in_valid && !rx_req_in_ready);
endmodule
bind aqh_async_queue_host_port aqh_port_sva #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .tx_req_data(tx_req_data),
    .tx_req_last(tx_req_last), .tx_req_valid(tx_req_valid), .tx_req_ready(tx_req_ready),
    .tx_resp_last(tx_resp_last), .tx_resp_valid(tx_resp_valid), .rx_req_in_valid(rx_req_in_valid),
    .rx_req_in_ready(rx_req_in_ready), .rx_req_out_valid(rx_req_out_valid)
);
`default_nettype wire

// >>> verilog/aqh_async_queue_host_port.sv
// Host port of the asynchronous packet queues: APB registers, transfer holding registers, four queues
//
// What this block does
// [R1] Undefined status word bits always read zero.
// [R2] Status bit 17 is high while the response holding register is empty.
// [R3] Status bit 16 is high while the request holding register is empty.
// [R4] Bits 15..12: receive response queue full, one left, five free, empty.
// [R5] Bits 11..8: receive request queue full, one left, five free, empty.
// [R6] Bits 7..4: transmit response queue full, one left, five free, empty.
// [R7] Bits 3..0: transmit request queue full, one left, five free, empty.
// [R8] Request-next write queues a first or middle quadlet for requests.
// [R9] Request-last write queues the closing quadlet of a request packet.
// [R10] Request write drops request write-ready until the quadlet enters its queue.
// [R11] Response-next write queues a first or middle quadlet for responses.
// [R12] Response-last write queues the closing quadlet of a response packet.
// [R13] Response write drops response write-ready until the quadlet enters its queue.
// [R14] Host writes next quadlets, then one last, waiting for write-ready each time.
// [R15] After reset both paths idle, queues empty, five free, no full flags.
`timescale 1ns/1ps
`default_nettype none

module aqh_async_queue_host_port
    import aqh_pkg::*;
#(
    parameter int QUEUE_DEPTH = AQH_QUEUE_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AQH_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    output logic [AQH_QUADLET_W-1:0] tx_req_data,
    output logic tx_req_last,
    output logic tx_req_valid,
    input wire logic tx_req_ready,
    output logic [AQH_QUADLET_W-1:0] tx_resp_data,
    output logic tx_resp_last,
    output logic tx_resp_valid,
    input wire logic tx_resp_ready,
    input wire logic [AQH_QUADLET_W-1:0] rx_req_in_data,
    input wire logic rx_req_in_last,
    input wire logic rx_req_in_valid,
    output logic rx_req_in_ready,
    input wire logic [AQH_QUADLET_W-1:0] rx_resp_in_data,
    input wire logic rx_resp_in_last,
    input wire logic rx_resp_in_valid,
    output logic rx_resp_in_ready,
    output logic [AQH_QUADLET_W-1:0] rx_req_out_data,
    output logic rx_req_out_last,
    output logic rx_req_out_valid,
    input wire logic rx_req_out_ready,
    output logic [AQH_QUADLET_W-1:0] rx_resp_out_data,
    output logic rx_resp_out_last,
    output logic rx_resp_out_valid,
    input wire logic rx_resp_out_ready
);

    localparam int ENTRY_W = AQH_QUADLET_W + 1;
    localparam int CNT_W = $clog2(QUEUE_DEPTH + 1);
    localparam int PTR_W = $clog2(QUEUE_DEPTH);
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(QUEUE_DEPTH);
    localparam logic [CNT_W-1:0] ONE_LEFT_C = CNT_W'(QUEUE_DEPTH - 1);
    localparam logic [CNT_W-1:0] FIVE_LIMIT_C = CNT_W'(QUEUE_DEPTH - AQH_FIVE);
    localparam logic [PTR_W-1:0] LAST_PTR_C = PTR_W'(QUEUE_DEPTH - 1);

    // Reset status relies on a depth that shows five free quadlets when empty
    if (QUEUE_DEPTH < AQH_MIN_DEPTH) begin : g_depth_check
        $error("QUEUE_DEPTH must be at least five");
    end

    // APB phase decode
    logic setup_phase;
    logic access_phase;
    logic access_write;
    logic access_read;
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign access_write = access_phase & pwrite;
    assign access_read = access_phase & ~pwrite;


    // Register hits taken in the access cycle only
    logic wr_req_next;
    logic wr_req_last;
    logic wr_resp_next;
    logic wr_resp_last;
    logic wr_irq_mask;
    logic rd_irq_status;
    assign wr_req_next = access_write && (paddr == AQH_OFF_TX_REQUEST_NEXT_QUADLET);
    assign wr_req_last = access_write && (paddr == AQH_OFF_TX_REQUEST_LAST_QUADLET);
    assign wr_resp_next = access_write && (paddr == AQH_OFF_TX_RESPONSE_NEXT_QUADLET);
    assign wr_resp_last = access_write && (paddr == AQH_OFF_TX_RESPONSE_LAST_QUADLET);
    assign wr_irq_mask = access_write && (paddr == AQH_OFF_IRQ_MASK);
    assign rd_irq_status = access_read && (paddr == AQH_OFF_IRQ_STATUS);

    // Queue-side handshakes, one slot per queue
    logic q_in_valid [AQH_NUM_QUEUES];
    logic q_in_ready [AQH_NUM_QUEUES];
    logic [ENTRY_W-1:0] q_in_data [AQH_NUM_QUEUES];
    logic q_out_valid [AQH_NUM_QUEUES];
    logic q_out_ready [AQH_NUM_QUEUES];
    logic [ENTRY_W-1:0] q_out_data [AQH_NUM_QUEUES];
    logic [3:0] q_flags [AQH_NUM_QUEUES];

    // Transmit transfer holding registers
    logic req_hold_valid;
    logic req_hold_last;
    logic [AQH_QUADLET_W-1:0] req_hold_data;
    logic resp_hold_valid;
    logic resp_hold_last;
    logic [AQH_QUADLET_W-1:0] resp_hold_data;
    logic req_write_hit;
    logic resp_write_hit;
    logic req_moved;
    logic resp_moved;
    logic tx_req_write_ready;
    logic tx_resp_write_ready;

    assign req_write_hit = wr_req_next | wr_req_last;
    assign resp_write_hit = wr_resp_next | wr_resp_last;
    assign req_moved = req_hold_valid & q_in_ready[AQH_Q_TX_REQ];

    assign resp_moved = resp_hold_valid & q_in_ready[AQH_Q_TX_RESP];

    // Write-ready and idle share one source: holding register empty
    assign tx_req_write_ready = ~req_hold_valid; // [R10]
    assign tx_resp_write_ready = ~resp_hold_valid; // [R13]

    // Write while occupied is dropped; the host is expected to wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_hold_valid <= 1'b0;
            req_hold_last <= 1'b0;
            req_hold_data <= '0;
        end else if (req_write_hit && !req_hold_valid) begin // [R14]
            req_hold_valid <= 1'b1; // [R10]
            req_hold_last <= wr_req_last; // [R8] [R9]
            req_hold_data <= pwdata;
        end else if (req_moved) begin
            req_hold_valid <= 1'b0; // [R10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_hold_valid <= 1'b0;
            resp_hold_last <= 1'b0;
            resp_hold_data <= '0;
        end else if (resp_write_hit && !resp_hold_valid) begin // [R14]
            resp_hold_valid <= 1'b1; // [R13]
            resp_hold_last <= wr_resp_last; // [R11] [R12]
            resp_hold_data <= pwdata;
        end else if (resp_moved) begin
            resp_hold_valid <= 1'b0; // [R13]
        end
    end

    // Queue inputs: holding registers on the transmit side, link on the receive side
    assign q_in_valid[AQH_Q_TX_REQ] = req_hold_valid; // [R8] [R9]
    assign q_in_data[AQH_Q_TX_REQ] = {req_hold_last, req_hold_data};
    assign q_in_valid[AQH_Q_TX_RESP] = resp_hold_valid; // [R11] [R12]
    assign q_in_data[AQH_Q_TX_RESP] = {resp_hold_last, resp_hold_data};
    assign q_in_valid[AQH_Q_RX_REQ] = rx_req_in_valid;
    assign q_in_data[AQH_Q_RX_REQ] = {rx_req_in_last, rx_req_in_data};
    assign q_in_valid[AQH_Q_RX_RESP] = rx_resp_in_valid;
    assign q_in_data[AQH_Q_RX_RESP] = {rx_resp_in_last, rx_resp_in_data};
    assign rx_req_in_ready = q_in_ready[AQH_Q_RX_REQ];
    assign rx_resp_in_ready = q_in_ready[AQH_Q_RX_RESP];

    // Queue outputs toward the link core and receive readers
    assign q_out_ready[AQH_Q_TX_REQ] = tx_req_ready;
    assign q_out_ready[AQH_Q_TX_RESP] = tx_resp_ready;
    assign q_out_ready[AQH_Q_RX_REQ] = rx_req_out_ready;
    assign q_out_ready[AQH_Q_RX_RESP] = rx_resp_out_ready;
    assign tx_req_valid = q_out_valid[AQH_Q_TX_REQ];
    assign {tx_req_last, tx_req_data} = q_out_data[AQH_Q_TX_REQ];
    assign tx_resp_valid = q_out_valid[AQH_Q_TX_RESP];
    assign {tx_resp_last, tx_resp_data} = q_out_data[AQH_Q_TX_RESP];
    assign rx_req_out_valid = q_out_valid[AQH_Q_RX_REQ];
    assign {rx_req_out_last, rx_req_out_data} = q_out_data[AQH_Q_RX_REQ];
    assign rx_resp_out_valid = q_out_valid[AQH_Q_RX_RESP];
    assign {rx_resp_out_last, rx_resp_out_data} = q_out_data[AQH_Q_RX_RESP];

    // Four identical circular queues, last-quadlet mark stored in the top bit
    for (genvar q = 0; q < AQH_NUM_QUEUES; q++) begin : g_queue
        logic [ENTRY_W-1:0] mem [QUEUE_DEPTH];
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
        logic push;
        logic pop;

        assign q_in_ready[q] = (count != DEPTH_C);
        assign q_out_valid[q] = (count != '0);
        assign q_out_data[q] = mem[rd_ptr];
        assign push = q_in_valid[q] & q_in_ready[q];
        assign pop = q_out_valid[q] & q_out_ready[q];

        // Storage has no reset; count and pointers guard every read
        always_ff @(posedge pclk) begin
            if (push) begin
                mem[wr_ptr] <= q_in_data[q];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                wr_ptr <= '0;
            end else if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR_C) ? '0 : wr_ptr + 1'b1;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                rd_ptr <= '0;
            end else if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR_C) ? '0 : rd_ptr + 1'b1;
            end
        end

        // Push and pop together leave the count unchanged
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                count <= '0; // [R15]
            end else if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end

        // Occupancy flags in nibble order: full, one left, five free, empty
        always_comb begin
            q_flags[q] = '0;
            q_flags[q][AQH_FLAG_FULL] = (count == DEPTH_C); // [R4] [R5] [R6] [R7]
            q_flags[q][AQH_FLAG_ONE_LEFT] = (count == ONE_LEFT_C); // [R4] [R5] [R6] [R7]
            q_flags[q][AQH_FLAG_FIVE_FREE] = (count <= FIVE_LIMIT_C); // [R4] [R5] [R6] [R7]
            q_flags[q][AQH_FLAG_EMPTY] = (count == '0); // [R4] [R5] [R6] [R7]
        end
    end

    // Status word assembly
    logic [31:0] status_word;
    always_comb begin
        status_word = '0; // [R1]
        status_word[AQH_TX_RESP_IDLE_BIT] = ~resp_hold_valid; // [R2]
        status_word[AQH_TX_REQ_IDLE_BIT] = ~req_hold_valid; // [R3]
        for (int i = 0; i < AQH_NUM_QUEUES; i++) begin
            status_word[AQH_NIBBLE_BASE[i] +: 4] = q_flags[i]; // [R4] [R5] [R6] [R7]
        end
    end


    // Interrupt events; overrun is a transfer write dropped while busy
    logic [AQH_IRQ_W-1:0] irq_events;
    always_comb begin
        irq_events = '0;
        irq_events[AQH_IRQ_TX_REQ_MOVED] = req_moved;
        irq_events[AQH_IRQ_TX_RESP_MOVED] = resp_moved;
        irq_events[AQH_IRQ_RX_REQ_ARRIVED] = rx_req_in_valid & q_in_ready[AQH_Q_RX_REQ];
        irq_events[AQH_IRQ_RX_RESP_ARRIVED] = rx_resp_in_valid & q_in_ready[AQH_Q_RX_RESP];
        irq_events[AQH_IRQ_TX_REQ_OVERRUN] = req_write_hit & req_hold_valid;
        irq_events[AQH_IRQ_TX_RESP_OVERRUN] = resp_write_hit & resp_hold_valid;
    end

    logic [AQH_IRQ_W-1:0] irq_status;
    logic [AQH_IRQ_W-1:0] irq_mask;
    logic [AQH_IRQ_W-1:0] irq_snapshot;

    // Snapshot taken with the read data so only reported bits get cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_snapshot <= '0;
        end else if (setup_phase && !pwrite && paddr == AQH_OFF_IRQ_STATUS) begin
            irq_snapshot <= irq_status;
        end
    end

    // New events win over the read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (rd_irq_status) begin
            irq_status <= (irq_status & ~irq_snapshot) | irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= AQH_IRQ_MASK_RESET;
        end else if (wr_irq_mask) begin
            irq_mask <= pwdata[AQH_IRQ_W-1:0];
        end
    end


    // Level output follows the masked next status, one cycle after an event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_status_masked());
        end
    end


    // Same update as the status register, so irq never lags a clear
    function automatic logic [AQH_IRQ_W-1:0] next_irq_status_masked();
        logic [AQH_IRQ_W-1:0] next_status;
        if (rd_irq_status) begin
            next_status = (irq_status & ~irq_snapshot) | irq_events;
        end else begin
            next_status = irq_status | irq_events;
        end
        return next_status & irq_mask;
    endfunction


    // Read mux and access legality
    logic [31:0] read_value;
    logic read_ok;
    logic write_ok;
    always_comb begin
        read_value = '0;
        read_ok = 1'b0;
        write_ok = 1'b0;
        if (paddr == AQH_OFF_ASYNC_QUEUE_STATUS) begin
            read_value = status_word; // [R1]
            read_ok = 1'b1;
        end else if (paddr == AQH_OFF_TX_REQUEST_NEXT_QUADLET || paddr == AQH_OFF_TX_REQUEST_LAST_QUADLET) begin
            write_ok = 1'b1;
        end else if (paddr == AQH_OFF_TX_RESPONSE_NEXT_QUADLET || paddr == AQH_OFF_TX_RESPONSE_LAST_QUADLET) begin
            write_ok = 1'b1;
        end else if (paddr == AQH_OFF_IRQ_STATUS) begin
            read_value[AQH_IRQ_W-1:0] = irq_status;
            read_ok = 1'b1;
        end else if (paddr == AQH_OFF_IRQ_MASK) begin
            read_value[AQH_IRQ_W-1:0] = irq_mask;
            read_ok = 1'b1;
            write_ok = 1'b1;
        end else if (paddr == AQH_OFF_WRITE_READY) begin
            read_value[AQH_WR_TX_REQ_READY_BIT] = tx_req_write_ready; // [R10]
            read_value[AQH_WR_TX_RESP_READY_BIT] = tx_resp_write_ready; // [R13]
            read_ok = 1'b1;
        end
    end

    // Read data registered in the setup cycle, stable through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_phase && !pwrite) begin
            prdata <= read_value;
        end
    end


    // Zero wait states: every access ends in its first access cycle
    assign pready = 1'b1;

    // Refused accesses change nothing besides the error response
    assign pslverr = access_phase & (pwrite ? ~write_ok : ~read_ok);

endmodule

`default_nettype wire
